// >>> src/gp_timer_pkg.sv
// constants shared by the dual timer/counter and its machine-cycle prescaler
// assumes byte-wide registers, each in the low byte of an aligned 32-bit word
package gp_timer_pkg;

  // ********************************
  // clocking
  // ********************************
  localparam int unsigned MCLK_HZ         = 25_000_000;
  localparam logic [3:0]  OSC_PER_MACHINE = 4'hC;

  // ********************************
  // register byte offsets
  // ********************************
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_T0_LOW = 8'h08;
  localparam logic [7:0] OFF_T0_HI  = 8'h0C;
  localparam logic [7:0] OFF_T1_LOW = 8'h10;
  localparam logic [7:0] OFF_T1_HI  = 8'h14;

  // ********************************
  // mode register fields
  // ********************************
  localparam int MODE0_LSB = 0;
  localparam int CT0_BIT   = 2;
  localparam int GATE0_BIT = 3;
  localparam int MODE1_LSB = 4;
  localparam int CT1_BIT   = 6;
  localparam int GATE1_BIT = 7;

  // ********************************
  // control register fields
  // ********************************
  localparam int RUN0_BIT = 4;
  localparam int OVF0_BIT = 5;
  localparam int RUN1_BIT = 6;
  localparam int OVF1_BIT = 7;

  // ********************************
  // reset values and modes
  // ********************************
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> src/machine_tick_if.sv
// machine-cycle tick and sampled falling-edge events between prescaler and timers
// assumes one clock domain, all signals are one-cycle pulses
`timescale 1ns/1ps
interface machine_tick_if;
  logic machine_tick;
  logic fall0;
  logic fall1;
  modport src (output machine_tick, output fall0, output fall1);
  modport dst (input machine_tick, input fall0, input fall1);
endinterface

// >>> src/machine_prescaler.sv
// divides mclk by twelve into machine cycles and samples the count inputs once per cycle
// assumes count inputs synchronous to mclk
`timescale 1ns/1ps
module machine_prescaler
  import gp_timer_pkg::*;
(
  input  wire logic    mclk,
  input  wire logic    reset,
  input  wire logic    count_input0,
  input  wire logic    count_input1,
  machine_tick_if.src  t
);

  logic [3:0] div;
  logic       sample0;
  logic       sample1;
  wire        last_osc = (div == OSC_PER_MACHINE - 4'h1);

  // ********************************
  // divider and samplers
  // ********************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      div            <= 4'h0;
      sample0        <= 1'b0;
      sample1        <= 1'b0;
      t.machine_tick <= 1'b0;
      t.fall0        <= 1'b0;
      t.fall1        <= 1'b0;
    end
    else
    begin
      div            <= last_osc ? 4'h0 : div + 4'h1;
      t.machine_tick <= last_osc;
      // previous sample high, this sample low: one event per two machine cycles at best
      t.fall0        <= last_osc & sample0 & ~count_input0;
      t.fall1        <= last_osc & sample1 & ~count_input1;
      if (last_osc)
      begin
        sample0 <= count_input0;
        sample1 <= count_input1;
      end
    end
  end

  // ********************************
  // checks
  // ********************************
  property p_tick_period;
    @(posedge mclk) disable iff (reset) t.machine_tick |-> ##12 t.machine_tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period not twelve");

  property p_tick_gap;
    @(posedge mclk) disable iff (reset) t.machine_tick |=> !t.machine_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too soon");

  property p_fall_on_tick;
    @(posedge mclk) disable iff (reset) (t.fall0 || t.fall1) |-> t.machine_tick;
  endproperty
  a_fall_on_tick: assert property (p_fall_on_tick) else $error("edge event off tick");

endmodule

// >>> src/dual_timer_counter.sv
// two 16-bit timer/counters with four modes behind an AXI4-Lite slave
// assumes count and gate pins synchronous to mclk; one outstanding read and write
`timescale 1ns/1ps
//
// Contract
// - two independent 16-bit timer or event counters
// - timer increments once per twelve-clock machine cycle
// - counter increments on high-then-low samples
// - new count visible the following machine cycle
// - falling edge takes two machine cycles
// - two-bit mode field per timer
// - mode 0: 13-bit, high byte plus low five
// - rollover to zero sets overflow flag
// - count when run and (no gate or pin high)
// - setting run keeps count contents
// - mode 1: full 16-bit count
// - mode 2: low byte reloads from high
// - split high byte: cycles, timer 1 run/flag
// - timer 1 stoppable via own mode 3
// - select bit chooses pin edges or cycles
// - overflow sets flag and raises request
// - control changes apply after the write completes
// - timer 1 mode 3 stops its counting
module dual_timer_counter
  import gp_timer_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              count_input0,
  input  wire logic              count_input1,
  input  wire logic              gate_interrupt_pin0,
  input  wire logic              gate_interrupt_pin1,
  output logic                   timer0_irq,
  output logic                   timer1_irq,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ********************************
  // increment step for one timer
  // ********************************
  // returns {overflow, high, low}
  function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi);
    logic [5:0]  lo5;
    logic [8:0]  hi9;
    logic [16:0] w17;
    logic [8:0]  lo9;
    lo5 = {1'b0, lo[4:0]} + 6'h01;
    hi9 = {1'b0, hi} + 9'h001;
    w17 = {1'b0, hi, lo} + 17'h00001;
    lo9 = {1'b0, lo} + 9'h001;
    case (m)
      MODE_13BIT:
      begin
        // upper three low-byte bits are left alone
        if (lo5[5])
          step = {hi9[8], hi9[7:0], lo[7:5], lo5[4:0]};
        else
          step = {1'b0, hi, lo[7:5], lo5[4:0]};
      end
      MODE_16BIT:
        step = w17;
      MODE_RELOAD:
        step = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, lo9[7:0]};
      default:
        step = {lo9[8], hi, lo9[7:0]};
    endcase
  endfunction

  machine_tick_if tk ();

  machine_prescaler u_prescaler (
    .mclk         (mclk),
    .reset        (reset),
    .count_input0 (count_input0),
    .count_input1 (count_input1),
    .t            (tk)
  );

  logic [7:0]        timer_mode_register;
  logic [7:0]        timer0_count_low;
  logic [7:0]        timer0_count_high;
  logic [7:0]        timer1_count_low;
  logic [7:0]        timer1_count_high;
  logic              timer0_run_bit;
  logic              timer1_run_bit;
  logic              timer0_overflow_flag;
  logic              timer1_overflow_flag;
  logic              aw_have;
  logic              w_have;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              wr_lane0;

  // ********************************
  // field decode
  // ********************************
  wire [1:0] mode0 = timer_mode_register[MODE0_LSB +: 2];
  wire [1:0] mode1 = timer_mode_register[MODE1_LSB +: 2];
  wire       ct0   = timer_mode_register[CT0_BIT];
  wire       ct1   = timer_mode_register[CT1_BIT];
  wire       gate0 = timer_mode_register[GATE0_BIT];
  wire       gate1 = timer_mode_register[GATE1_BIT];
  wire       t0_split = (mode0 == MODE_SPLIT);

  wire src0 = ct0 ? tk.fall0 : tk.machine_tick;
  wire src1 = ct1 ? tk.fall1 : tk.machine_tick;
  wire en0  = timer0_run_bit & (~gate0 | gate_interrupt_pin0) & src0;
  wire en1  = timer1_run_bit & (~gate1 | gate_interrupt_pin1) & src1 & (mode1 != MODE_SPLIT);
  wire en0h = t0_split & timer1_run_bit & tk.machine_tick;

  wire [16:0] step0 = step(mode0, timer0_count_low, timer0_count_high);
  wire [16:0] step1 = step(mode1, timer1_count_low, timer1_count_high);
  wire [7:0]  h0_inc = timer0_count_high + 8'h01;

  wire set_ovf0 = en0 & step0[16];
  wire set_ovf1 = (en0h & (timer0_count_high == 8'hFF)) | (en1 & step1[16] & ~t0_split);

  // ********************************
  // register write decode
  // ********************************
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire wr_ok   = wr_fire & wr_lane0;
  wire wr_mode = wr_ok & (wr_addr == ADDR_W'(OFF_MODE));
  wire wr_ctrl = wr_ok & (wr_addr == ADDR_W'(OFF_CTRL));
  wire wr_l0   = wr_ok & (wr_addr == ADDR_W'(OFF_T0_LOW));
  wire wr_h0   = wr_ok & (wr_addr == ADDR_W'(OFF_T0_HI));
  wire wr_l1   = wr_ok & (wr_addr == ADDR_W'(OFF_T1_LOW));
  wire wr_h1   = wr_ok & (wr_addr == ADDR_W'(OFF_T1_HI));
  wire wr_map  = (wr_addr == ADDR_W'(OFF_MODE)) | (wr_addr == ADDR_W'(OFF_CTRL)) |
                 (wr_addr == ADDR_W'(OFF_T0_LOW)) | (wr_addr == ADDR_W'(OFF_T0_HI)) |
                 (wr_addr == ADDR_W'(OFF_T1_LOW)) | (wr_addr == ADDR_W'(OFF_T1_HI));

  // writes override the counting logic; hardware flag set beats software clear
  wire [7:0] next_l0 = wr_l0 ? wr_data : (en0 ? step0[7:0] : timer0_count_low);
  wire [7:0] next_h0 = wr_h0 ? wr_data :
                       (t0_split ? (en0h ? h0_inc : timer0_count_high) :
                       (en0 ? step0[15:8] : timer0_count_high));
  wire [7:0] next_l1 = wr_l1 ? wr_data : (en1 ? step1[7:0] : timer1_count_low);
  wire [7:0] next_h1 = wr_h1 ? wr_data : (en1 ? step1[15:8] : timer1_count_high);
  wire next_f0 = set_ovf0 | (wr_ctrl ? wr_data[OVF0_BIT] : timer0_overflow_flag);
  wire next_f1 = set_ovf1 | (wr_ctrl ? wr_data[OVF1_BIT] : timer1_overflow_flag);

  // ********************************
  // timer state
  // ********************************
  // run bits only gate the increment, so setting run resumes from the held count
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      timer_mode_register  <= RST_BYTE;
      timer0_count_low     <= RST_BYTE;
      timer0_count_high    <= RST_BYTE;
      timer1_count_low     <= RST_BYTE;
      timer1_count_high    <= RST_BYTE;
      timer0_run_bit       <= 1'b0;
      timer1_run_bit       <= 1'b0;
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
      timer0_irq           <= 1'b0;
      timer1_irq           <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        timer_mode_register <= wr_data;
      if (wr_ctrl)
      begin
        timer0_run_bit <= wr_data[RUN0_BIT];
        timer1_run_bit <= wr_data[RUN1_BIT];
      end
      timer0_count_low     <= next_l0;
      timer0_count_high    <= next_h0;
      timer1_count_low     <= next_l1;
      timer1_count_high    <= next_h1;
      timer0_overflow_flag <= next_f0;
      timer1_overflow_flag <= next_f1;
      timer0_irq           <= next_f0;
      timer1_irq           <= next_f1;
    end
  end

  // ********************************
  // AXI4-Lite write channel
  // ********************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= RST_BYTE;
      wr_lane0      <= 1'b0;
    end
    else
    begin
      if (s_axi_awready & s_axi_awvalid)
      begin
        s_axi_awready <= 1'b0;
        aw_have       <= 1'b1;
        wr_addr       <= s_axi_awaddr;
      end
      else if (~aw_have & ~s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wready & s_axi_wvalid)
      begin
        s_axi_wready <= 1'b0;
        w_have       <= 1'b1;
        wr_data      <= s_axi_wdata[7:0];
        wr_lane0     <= s_axi_wstrb[0];
      end
      else if (~w_have & ~s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (wr_fire)
      begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ********************************
  // AXI4-Lite read channel
  // ********************************
  wire [7:0] ctrl_view = {timer1_overflow_flag, timer1_run_bit, timer0_overflow_flag, timer0_run_bit, 4'h0};
  wire       rd_map    = (s_axi_araddr == ADDR_W'(OFF_MODE)) | (s_axi_araddr == ADDR_W'(OFF_CTRL)) |
                         (s_axi_araddr == ADDR_W'(OFF_T0_LOW)) | (s_axi_araddr == ADDR_W'(OFF_T0_HI)) |
                         (s_axi_araddr == ADDR_W'(OFF_T1_LOW)) | (s_axi_araddr == ADDR_W'(OFF_T1_HI));
  wire [7:0] rd_byte   = (s_axi_araddr == ADDR_W'(OFF_MODE))   ? timer_mode_register :
                         (s_axi_araddr == ADDR_W'(OFF_CTRL))   ? ctrl_view :
                         (s_axi_araddr == ADDR_W'(OFF_T0_LOW)) ? timer0_count_low :
                         (s_axi_araddr == ADDR_W'(OFF_T0_HI))  ? timer0_count_high :
                         (s_axi_araddr == ADDR_W'(OFF_T1_LOW)) ? timer1_count_low :
                         (s_axi_araddr == ADDR_W'(OFF_T1_HI))  ? timer1_count_high : 8'h00;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arready & s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid)
      s_axi_rvalid <= ~s_axi_rready;
    else
      s_axi_arready <= 1'b1;
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_run_off_holds;
    (!timer0_run_bit && !wr_fire && !t0_split) |=> $stable({timer0_count_high, timer0_count_low});
  endproperty
  a_run_off_holds: assert property (p_run_off_holds) else $error("timer 0 moved while stopped");

  property p_mode1_wrap;
    (en0 && mode0 == MODE_16BIT && {timer0_count_high, timer0_count_low} == 16'hFFFF && !wr_fire)
      |=> (timer0_overflow_flag && {timer0_count_high, timer0_count_low} == 16'h0000);
  endproperty
  a_mode1_wrap: assert property (p_mode1_wrap) else $error("16-bit rollover wrong");

  property p_mode0_carry;
    (en0 && mode0 == MODE_13BIT && timer0_count_low[4:0] == 5'h1F && !wr_fire)
      |=> (timer0_count_high == $past(timer0_count_high) + 8'h01 && timer0_count_low[4:0] == 5'h00);
  endproperty
  a_mode0_carry: assert property (p_mode0_carry) else $error("13-bit carry wrong");

  property p_mode2_reload;
    (en0 && mode0 == MODE_RELOAD && timer0_count_low == 8'hFF && !wr_fire)
      |=> (timer0_count_low == $past(timer0_count_high) && $stable(timer0_count_high) && timer0_overflow_flag);
  endproperty
  a_mode2_reload: assert property (p_mode2_reload) else $error("reload wrong");

  property p_t1_mode3_stop;
    (mode1 == MODE_SPLIT && !wr_fire) |=> $stable({timer1_count_high, timer1_count_low});
  endproperty
  a_t1_mode3_stop: assert property (p_t1_mode3_stop) else $error("timer 1 counted in mode 3");

  property p_counter_needs_edge;
    (ct0 && mode0 == MODE_16BIT && !wr_fire) ##1 $changed({timer0_count_high, timer0_count_low})
      |-> $past(tk.fall0);
  endproperty
  a_counter_needs_edge: assert property (p_counter_needs_edge) else $error("count without edge");

  property p_set_beats_clear;
    set_ovf0 |=> (timer0_overflow_flag && timer0_irq);
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("overflow lost");

  property p_split_high;
    (en0h && !wr_fire && timer0_count_high == 8'hFF) |=> (timer1_overflow_flag && timer0_count_high == 8'h00);
  endproperty
  a_split_high: assert property (p_split_high) else $error("split high byte wrong");

endmodule

// >>> tb/count_source.sv
// external event source and gate pins that sit outside the dual timer/counter
// assumes the bench supplies mclk; one machine cycle is twelve mclk periods
`timescale 1ns/1ps
module count_source
(
  input  wire logic mclk,
  output logic      count_input0,
  output logic      count_input1,
  output logic      gate_interrupt_pin0,
  output logic      gate_interrupt_pin1
);
  initial
  begin
    count_input0        = 1'b0;
    count_input1        = 1'b0;
    gate_interrupt_pin0 = 1'b0;
    gate_interrupt_pin1 = 1'b0;
  end

  // ********************************
  // stimulus tasks
  // ********************************
  // each level stands exactly one machine cycle: the fastest legal rate
  task automatic pulses(input bit ch, input int n);
    repeat (2 * n)
    begin
      @(posedge mclk);
      if (ch) count_input1 <= ~count_input1;
      else count_input0 <= ~count_input0;
      repeat (11) @(posedge mclk);
    end
  endtask

  task automatic gate(input bit ch, input logic lvl);
    @(posedge mclk);
    if (ch) gate_interrupt_pin1 <= lvl;
    else gate_interrupt_pin0 <= lvl;
  endtask
endmodule

// >>> tb/test_dual_timer_counter.sv
// self-checking bench for the dual timer/counter over its AXI4-Lite port
// assumes count_source drives the count and gate pins
`timescale 1ns/1ps
module test_dual_timer_counter
  import gp_timer_pkg::*;
;
  logic        mclk, reset, timer0_irq, timer1_irq;
  logic        count_input0, count_input1, gate_interrupt_pin0, gate_interrupt_pin1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, strb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          bad_count, num_checks, cyc, k;
  logic [7:0]  r_lo, r_hi;

  dual_timer_counter DUT (.mclk, .reset, .count_input0, .count_input1, .gate_interrupt_pin0,
    .gate_interrupt_pin1, .timer0_irq, .timer1_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  count_source src (.mclk, .count_input0, .count_input1, .gate_interrupt_pin0, .gate_interrupt_pin1);

  always #20 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  // ********************************
  // checking
  // ********************************
  task automatic cmp_read(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t read got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t write response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_irq(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t irq %b expected %b", $time, got, exp);
    end
  endtask

  // oldest note is matched against each answer as it appears
  always @(posedge mclk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
    begin
      if (exp_r.size() == 0)
      begin
        bad_count++;
        $display("[FAIL] %0t read answer with no note", $time);
      end
      else cmp_read({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
    begin
      if (exp_b.size() == 0)
      begin
        bad_count++;
        $display("[FAIL] %0t write response with no note", $time);
      end
      else cmp_resp(s_axi_bresp, exp_b.pop_front());
    end
  end

  // ********************************
  // bus tasks
  // ********************************
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    exp_b.push_back(er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
    if (n >= 200)
    begin
      bad_count++;
      $display("[FAIL] %0t write never answered", $time);
    end
    @(posedge mclk);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    exp_r.push_back({er, 24'h000000, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    if (n >= 200)
    begin
      bad_count++;
      $display("[FAIL] %0t read never answered", $time);
    end
    @(posedge mclk);
  endtask

  // ********************************
  // reference model and scenarios
  // ********************************
  function automatic logic [16:0] model(input logic [1:0] m, input logic [7:0] lo, hi, input int n);
    logic [7:0] l, h;
    logic       o;
    l = lo;
    h = hi;
    o = 1'b0;
    repeat (n)
    begin
      if (m == MODE_13BIT && l[4:0] == 5'h1F) {o, h} = {o | (h == 8'hFF), h + 8'h01};
      if (m == MODE_13BIT) l[4:0] = l[4:0] + 5'h01;
      else if (m == MODE_16BIT) {o, h, l} = {o | ({h, l} == 16'hFFFF), {h, l} + 16'h0001};
      else if (m == MODE_RELOAD) {o, l} = (l == 8'hFF) ? {1'b1, h} : {o, l + 8'h01};
      else {o, l} = {o | (l == 8'hFF), l + 8'h01};
    end
    return {o, h, l};
  endfunction

  // run for exactly n machine cycles between two equal-latency writes, stop by the gate
  task automatic timer_run(input bit t, input logic [1:0] m, input logic [7:0] lo, hi, input int n,
                           input logic [7:0] run);
    logic [7:0]  base, md;
    logic [16:0] e;
    int          st;
    base = t ? OFF_T1_LOW : OFF_T0_LOW;
    md = t ? {2'b00, m, 4'h0} : {6'h00, m};
    e = model(m, lo, hi, (t && m == MODE_SPLIT) ? 0 : n);
    axi_write(OFF_CTRL, 8'h00, RESP_OKAY);
    axi_write(OFF_MODE, md, RESP_OKAY);
    axi_write(base, lo, RESP_OKAY);
    axi_write(base + 8'h04, hi, RESP_OKAY);
    st = cyc;
    axi_write(OFF_CTRL, run, RESP_OKAY);
    while (cyc < st + 12 * n) @(posedge mclk);
    axi_write(OFF_MODE, md | (t ? 8'h80 : 8'h08), RESP_OKAY);
    axi_read(base, e[7:0], RESP_OKAY);
    axi_read(base + 8'h04, e[15:8], RESP_OKAY);
    axi_read(OFF_CTRL, run | (e[16] ? (t ? 8'h80 : 8'h20) : 8'h00), RESP_OKAY);
    cmp_irq(t ? timer1_irq : timer0_irq, e[16]);
  endtask

  task automatic counter_run(input bit t);
    logic [7:0] base;
    base = t ? OFF_T1_LOW : OFF_T0_LOW;
    axi_write(OFF_CTRL, 8'h00, RESP_OKAY);
    axi_write(OFF_MODE, t ? 8'hD0 : 8'h0D, RESP_OKAY);
    axi_write(base, 8'hFE, RESP_OKAY);
    axi_write(base + 8'h04, 8'hFF, RESP_OKAY);
    axi_write(OFF_CTRL, t ? 8'h40 : 8'h10, RESP_OKAY);
    src.gate(t, 1'b1);
    src.pulses(t, 3);
    repeat (24) @(posedge mclk);
    src.gate(t, 1'b0);
    src.pulses(t, 2);
    repeat (24) @(posedge mclk);
    axi_read(base, 8'h01, RESP_OKAY);
    axi_read(base + 8'h04, 8'h00, RESP_OKAY);
    axi_read(OFF_CTRL, t ? 8'hC0 : 8'h30, RESP_OKAY);
  endtask

  // timer 0 high byte under timer 1's run bit; timer 1 parked in its own mode 3
  task automatic split_high_run(input logic [7:0] hi, input int n);
    logic [16:0] e;
    int          st;
    e = model(MODE_SPLIT, hi, 8'h00, n);
    axi_write(OFF_CTRL, 8'h00, RESP_OKAY);
    axi_write(OFF_MODE, 8'h33, RESP_OKAY);
    axi_write(OFF_T0_LOW, 8'h5A, RESP_OKAY);
    axi_write(OFF_T0_HI, hi, RESP_OKAY);
    axi_write(OFF_T1_LOW, 8'hA5, RESP_OKAY);
    st = cyc;
    axi_write(OFF_CTRL, 8'h40, RESP_OKAY);
    while (cyc < st + 12 * n) @(posedge mclk);
    axi_write(OFF_MODE, 8'h30, RESP_OKAY);
    axi_read(OFF_T0_LOW, 8'h5A, RESP_OKAY);
    axi_read(OFF_T0_HI, e[7:0], RESP_OKAY);
    axi_read(OFF_T1_LOW, 8'hA5, RESP_OKAY);
    axi_read(OFF_CTRL, e[16] ? 8'hC0 : 8'h40, RESP_OKAY);
    cmp_irq(timer1_irq, e[16]);
  endtask

  task automatic finish_test;
    bad_count += exp_r.size() + exp_b.size();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test;
  end

  initial
  begin
    {mclk, cyc, bad_count, num_checks} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    strb = 4'hF;
    reset = 1'b1;
    k = $urandom(30607);
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 6; i++)
      axi_read(8'(4 * i), RST_BYTE, RESP_OKAY);
    axi_read(8'h18, 8'h00, RESP_SLVERR);
    axi_write(8'h1C, 8'hAA, RESP_SLVERR);
    strb = 4'h0;
    axi_write(OFF_T0_LOW, 8'h77, RESP_OKAY);
    strb = 4'hF;
    axi_read(OFF_T0_LOW, 8'h00, RESP_OKAY);
    r_lo = 8'hF8 | 8'($urandom & 7);
    k = 8 + $urandom % 4;
    timer_run(0, MODE_16BIT, r_lo, 8'hFF, k, 8'h10);
    r_lo = 8'($urandom);
    r_hi = 8'($urandom);
    timer_run(1, MODE_16BIT, r_lo, r_hi, 3, 8'h40);
    timer_run(0, MODE_13BIT, 8'hFD, 8'hFF, 4, 8'h10);
    timer_run(1, MODE_RELOAD, 8'hFE, 8'hFD, 5, 8'h40);
    timer_run(0, MODE_SPLIT, 8'hFD, 8'h55, 5, 8'h10);
    timer_run(1, MODE_SPLIT, 8'h12, 8'h34, 5, 8'h40);
    split_high_run(8'hFD, 4);
    counter_run(0);
    counter_run(1);
    finish_test;
  end
endmodule
